// [hw/lcs_defines.svh]
// Register offsets, reset values, field positions and counts of the control switch block
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define LCS_NUM_SW        5
`define LCS_ADDR_W        8
`define LCS_SEL_W         3
`define LCS_LABEL_CHARS   32
`define LCS_LABEL_WORDS   8
`define LCS_ACC_W         2

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each except the label block of 8 words per switch)
// ----------------------------------------------------------------------------
`define LCS_OFF_STATE     8'h00
`define LCS_OFF_ACCESS    8'h04
`define LCS_OFF_EVSEL     8'h08
`define LCS_OFF_IRQ_STAT  8'h0C
`define LCS_OFF_IRQ_MASK  8'h10
`define LCS_OFF_STAMP     8'h14
`define LCS_OFF_LABEL     8'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LCS_EVSEL_ON_BIT  0
`define LCS_EVSEL_OFF_BIT 1
`define LCS_IRQ_OFF_LSB   5
`define LCS_LBL_SW_LSB    5
`define LCS_LBL_WORD_LSB  2
`define LCS_LBL_DIGIT_LSB 16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LCS_RST_ACCESS    2'h2
`define LCS_RST_EVSEL     2'h3
`define LCS_RST_IRQ_MASK  10'h000
`define LCS_LABEL_W0      32'h7469_7753
`define LCS_LABEL_W1      32'h0000_6863
`define LCS_ASCII_ONE     8'h31

`endif

// [hw/lcs_pkg.sv]
// Types shared by the control switch block
package lcs_pkg;

  // Ascending operator access levels
  typedef enum logic [1:0] {
    LCS_LVL_USER,
    LCS_LVL_OPERATOR,
    LCS_LVL_CONFIGURATOR,
    LCS_LVL_SUPER
  } lcs_level_type;

  typedef logic [31:0] lcs_word_type;

endpackage : lcs_pkg

// [hw/lcs_bank_if.sv]
// Command and state carrier between the control logic and the switch bank
`timescale 1ns/1ps
interface lcs_bank_if #(
  parameter int NUM_SW = 5
);
  logic [NUM_SW-1:0] set_on;
  logic [NUM_SW-1:0] set_off;
  logic [NUM_SW-1:0] state;
  logic [NUM_SW-1:0] chg_on;
  logic [NUM_SW-1:0] chg_off;

  modport bank (
    input  set_on,
    input  set_off,
    output state,
    output chg_on,
    output chg_off
  );

  modport ctrl (
    output set_on,
    output set_off,
    input  state,
    input  chg_on,
    input  chg_off
  );
endinterface : lcs_bank_if

// [hw/lcs_switch_bank.sv]
// Bank of independent latching switches with change pulses
`timescale 1ns/1ps
module lcs_switch_bank
  import lcs_pkg::*;
#(
  parameter int NUM_SW = 5
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  lcs_bank_if.bank  bank_if
);

  logic [NUM_SW-1:0] state_q;
  logic [NUM_SW-1:0] chg_on_q;
  logic [NUM_SW-1:0] chg_off_q;

  // --------------------------------------------------------------------------
  // One latch per switch
  // --------------------------------------------------------------------------
  for (genvar s = 0; s < NUM_SW; s++) begin : g_sw
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        state_q[s]   <= 1'b0;
        chg_on_q[s]  <= 1'b0;
        chg_off_q[s] <= 1'b0;
      end else begin
        chg_on_q[s]  <= bank_if.set_on[s] & ~state_q[s];
        chg_off_q[s] <= bank_if.set_off[s] & state_q[s];
        if (bank_if.set_on[s]) begin
          state_q[s] <= 1'b1;
        end else if (bank_if.set_off[s]) begin
          state_q[s] <= 1'b0;
        end
      end
    end
  end

  assign bank_if.state   = state_q;
  assign bank_if.chg_on  = chg_on_q;
  assign bank_if.chg_off = chg_off_q;

endmodule // lcs_switch_bank

// [hw/lcs_top.sv]
// Latching control switch block: command gating, events, labels and registers
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lcs_defines.svh"
module lcs_top
  import lcs_pkg::*;
#(
  parameter int NUM_SW = `LCS_NUM_SW
) (
  input  wire logic                   REF_CLK_IN,
  input  wire logic                   SRST_IN,
  input  wire logic [`LCS_ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [31:0]            REG_WDATA_IN,
  input  wire logic                   REG_WR_IN,
  input  wire logic                   REG_RD_IN,
  output logic      [31:0]            REG_RDATA_OUT,
  input  wire logic                   PANEL_CMD_VALID_IN,
  input  wire logic [`LCS_SEL_W-1:0]  PANEL_CMD_SWITCH_IN,
  input  wire logic                   PANEL_CMD_ON_IN,
  input  wire lcs_level_type          PANEL_LEVEL_IN,
  input  wire logic                   REMOTE_CMD_VALID_IN,
  input  wire logic [`LCS_SEL_W-1:0]  REMOTE_CMD_SWITCH_IN,
  input  wire logic                   REMOTE_CMD_ON_IN,
  output logic      [NUM_SW-1:0]      SWITCH_OUT,
  output logic      [NUM_SW-1:0]      EVT_VALID_OUT,
  output logic      [NUM_SW-1:0]      EVT_STATE_OUT,
  output logic      [31:0]            EVT_STAMP_OUT,
  output logic                        IRQ_OUT
);

  localparam int IRQ_W = 2 * NUM_SW;

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [`LCS_ACC_W*NUM_SW-1:0] access_q;
  logic [1:0]                   evsel_q;
  logic [IRQ_W-1:0]             irq_stat_q;
  logic [IRQ_W-1:0]             irq_mask_q;
  logic [31:0]                  stamp_q;
  lcs_word_type                 label_q [NUM_SW][`LCS_LABEL_WORDS];
  logic [31:0]                  rdata_q;
  logic [NUM_SW-1:0]            switch_q;
  logic [NUM_SW-1:0]            evt_valid_q;
  logic [NUM_SW-1:0]            evt_state_q;
  logic [31:0]                  evt_stamp_q;
  logic                         irq_q;

  lcs_bank_if #(.NUM_SW(NUM_SW)) bank_if ();

  lcs_switch_bank #(
    .NUM_SW (NUM_SW)
  ) u_bank (
    .clk_in  (REF_CLK_IN),
    .srst_in (SRST_IN),
    .bank_if (bank_if)
  );

  // --------------------------------------------------------------------------
  // Command gating
  // --------------------------------------------------------------------------
  // The remote link wins over the panel when both aim at the same switch in
  // one cycle; the remote unit is the supervisory source.
  logic [NUM_SW-1:0] set_on_d;
  logic [NUM_SW-1:0] set_off_d;

  for (genvar s = 0; s < NUM_SW; s++) begin : g_cmd
    logic          remote_hit;
    logic          panel_hit;
    lcs_level_type min_level;

    assign min_level = lcs_level_type'(access_q[s*`LCS_ACC_W +: `LCS_ACC_W]);
    assign remote_hit = REMOTE_CMD_VALID_IN && (REMOTE_CMD_SWITCH_IN == `LCS_SEL_W'(s));
    assign panel_hit = PANEL_CMD_VALID_IN && (PANEL_CMD_SWITCH_IN == `LCS_SEL_W'(s))
                       && (PANEL_LEVEL_IN >= min_level);

    always_comb begin
      set_on_d[s]  = 1'b0;
      set_off_d[s] = 1'b0;
      if (remote_hit) begin
        set_on_d[s]  = REMOTE_CMD_ON_IN;
        set_off_d[s] = ~REMOTE_CMD_ON_IN;
      end else if (panel_hit) begin
        set_on_d[s]  = PANEL_CMD_ON_IN;
        set_off_d[s] = ~PANEL_CMD_ON_IN;
      end
    end
  end

  assign bank_if.set_on  = set_on_d;
  assign bank_if.set_off = set_off_d;

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  logic [`LCS_ADDR_W-1:0] lbl_off;
  logic [2:0]             lbl_sw;
  logic [2:0]             lbl_word;
  logic                   lbl_hit;

  assign lbl_off  = REG_ADDR_IN - `LCS_OFF_LABEL;
  assign lbl_sw   = lbl_off[`LCS_LBL_SW_LSB +: 3];
  assign lbl_word = lbl_off[`LCS_LBL_WORD_LSB +: 3];
  assign lbl_hit  = (REG_ADDR_IN >= `LCS_OFF_LABEL) && (lbl_off[1:0] == 2'h0)
                    && (32'(lbl_sw) < NUM_SW);

  logic wr_access;
  logic wr_evsel;
  logic wr_stat;
  logic wr_mask;

  assign wr_access = REG_WR_IN && (REG_ADDR_IN == `LCS_OFF_ACCESS);
  assign wr_evsel  = REG_WR_IN && (REG_ADDR_IN == `LCS_OFF_EVSEL);
  assign wr_stat   = REG_WR_IN && (REG_ADDR_IN == `LCS_OFF_IRQ_STAT);
  assign wr_mask   = REG_WR_IN && (REG_ADDR_IN == `LCS_OFF_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  for (genvar s = 0; s < NUM_SW; s++) begin : g_acc
    always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
        access_q[s*`LCS_ACC_W +: `LCS_ACC_W] <= `LCS_RST_ACCESS;
      end else if (wr_access) begin
        access_q[s*`LCS_ACC_W +: `LCS_ACC_W] <= REG_WDATA_IN[s*`LCS_ACC_W +: `LCS_ACC_W];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      evsel_q <= `LCS_RST_EVSEL;
    end else if (wr_evsel) begin
      evsel_q <= REG_WDATA_IN[1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      irq_mask_q <= `LCS_RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= REG_WDATA_IN[IRQ_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Switch labels
  // --------------------------------------------------------------------------
  // Labels live in flip-flops only; they steer nothing and exist for software
  // to keep one human-readable name beside each switch.
  for (genvar s = 0; s < NUM_SW; s++) begin : g_lbl_sw
    for (genvar w = 0; w < `LCS_LABEL_WORDS; w++) begin : g_lbl_word
      lcs_word_type rst_word;

      if (w == 0) begin : g_w0
        assign rst_word = `LCS_LABEL_W0;
      end else if (w == 1) begin : g_w1
        assign rst_word = `LCS_LABEL_W1
                          | (32'(`LCS_ASCII_ONE + 8'(s)) << `LCS_LBL_DIGIT_LSB);
      end else begin : g_wn
        assign rst_word = '0;
      end

      always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
          label_q[s][w] <= rst_word;
        end else if (REG_WR_IN && lbl_hit && (lbl_sw == 3'(s)) && (lbl_word == 3'(w))) begin
          label_q[s][w] <= REG_WDATA_IN;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Time stamp
  // --------------------------------------------------------------------------
  // Free-running tick count; wraps after 2^32 cycles, software extends it.
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      stamp_q <= '0;
    end else begin
      stamp_q <= stamp_q + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // Events
  // --------------------------------------------------------------------------
  logic [NUM_SW-1:0] keep_on;
  logic [NUM_SW-1:0] keep_off;

  assign keep_on  = bank_if.chg_on & {NUM_SW{evsel_q[`LCS_EVSEL_ON_BIT]}};
  assign keep_off = bank_if.chg_off & {NUM_SW{evsel_q[`LCS_EVSEL_OFF_BIT]}};

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      evt_valid_q <= '0;
      evt_state_q <= '0;
      evt_stamp_q <= '0;
    end else begin
      evt_valid_q <= keep_on | keep_off;
      evt_state_q <= bank_if.state;
      if (|(keep_on | keep_off)) begin
        evt_stamp_q <= stamp_q;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      switch_q <= '0;
    end else begin
      switch_q <= bank_if.state;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  // A change in the same cycle as a write-one-to-clear keeps its bit set.
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {bank_if.chg_off, bank_if.chg_on};
  assign irq_clr = wr_stat ? REG_WDATA_IN[IRQ_W-1:0] : '0;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  lcs_word_type rd_d;

  always_comb begin
    rd_d = '0;
    case (REG_ADDR_IN)
      `LCS_OFF_STATE: begin
        rd_d[NUM_SW-1:0] = bank_if.state;
      end
      `LCS_OFF_ACCESS: begin
        rd_d[`LCS_ACC_W*NUM_SW-1:0] = access_q;
      end
      `LCS_OFF_EVSEL: begin
        rd_d[1:0] = evsel_q;
      end
      `LCS_OFF_IRQ_STAT: begin
        rd_d[IRQ_W-1:0] = irq_stat_q;
      end
      `LCS_OFF_IRQ_MASK: begin
        rd_d[IRQ_W-1:0] = irq_mask_q;
      end
      `LCS_OFF_STAMP: begin
        rd_d = stamp_q;
      end
      default: begin
        if (lbl_hit) begin
          rd_d = label_q[lbl_sw][lbl_word];
        end
      end
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      rdata_q <= '0;
    end else if (REG_RD_IN) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign REG_RDATA_OUT = rdata_q;
  assign SWITCH_OUT    = switch_q;
  assign EVT_VALID_OUT = evt_valid_q;
  assign EVT_STATE_OUT = evt_state_q;
  assign EVT_STAMP_OUT = evt_stamp_q;
  assign IRQ_OUT       = irq_q;

endmodule // lcs_top

// [test/lcs_top_properties.sv]
// Port checker for the latching control switch block
`timescale 1ns/1ps
module lcs_top_checker
  import lcs_pkg::*;
#(
  parameter int NUM_SW = 5
) (
  input wire logic              REF_CLK_IN,
  input wire logic              SRST_IN,
  input wire logic              REG_WR_IN,
  input wire logic              PANEL_CMD_VALID_IN,
  input wire logic [2:0]        PANEL_CMD_SWITCH_IN,
  input wire logic              PANEL_CMD_ON_IN,
  input wire lcs_level_type     PANEL_LEVEL_IN,
  input wire logic              REMOTE_CMD_VALID_IN,
  input wire logic [2:0]        REMOTE_CMD_SWITCH_IN,
  input wire logic              REMOTE_CMD_ON_IN,
  input wire logic [NUM_SW-1:0] SWITCH_OUT,
  input wire logic [NUM_SW-1:0] EVT_VALID_OUT,
  input wire logic [NUM_SW-1:0] EVT_STATE_OUT,
  input wire logic [31:0]       EVT_STAMP_OUT,
  input wire logic              IRQ_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_idle2;
    (!PANEL_CMD_VALID_IN && !REMOTE_CMD_VALID_IN) [*2];
  endsequence
  sequence s_rem;
    REMOTE_CMD_VALID_IN && REMOTE_CMD_SWITCH_IN < 3'h5;
  endsequence
  // Super level always passes; remote on the same switch would win
  sequence s_pan;
    PANEL_CMD_VALID_IN && PANEL_LEVEL_IN == LCS_LVL_SUPER && PANEL_CMD_SWITCH_IN < 3'h5 &&
      !(REMOTE_CMD_VALID_IN && REMOTE_CMD_SWITCH_IN == PANEL_CMD_SWITCH_IN);
  endsequence

  property p_hold;
    s_idle2 |=> $stable(SWITCH_OUT);
  endproperty
  property p_remote;
    s_rem |-> ##2 SWITCH_OUT[$past(REMOTE_CMD_SWITCH_IN, 2)] == $past(REMOTE_CMD_ON_IN, 2);
  endproperty
  property p_panel;
    s_pan |-> ##2 SWITCH_OUT[$past(PANEL_CMD_SWITCH_IN, 2)] == $past(PANEL_CMD_ON_IN, 2);
  endproperty
  property p_evchg;
    EVT_VALID_OUT != '0 |-> ((SWITCH_OUT ^ $past(SWITCH_OUT)) & EVT_VALID_OUT) == EVT_VALID_OUT;
  endproperty
  property p_evstate;
    (EVT_STATE_OUT & EVT_VALID_OUT) == (SWITCH_OUT & EVT_VALID_OUT);
  endproperty
  property p_stamp;
    EVT_VALID_OUT == '0 |-> $stable(EVT_STAMP_OUT);
  endproperty
  property p_cause;
    EVT_VALID_OUT != '0 |-> $past(PANEL_CMD_VALID_IN, 2) || $past(REMOTE_CMD_VALID_IN, 2);
  endproperty
  property p_irq;
    $rose(IRQ_OUT) |-> $past(PANEL_CMD_VALID_IN, 3) || $past(REMOTE_CMD_VALID_IN, 3) || $past(REG_WR_IN, 2);
  endproperty

  a_hold: assert property (p_hold) else $error("switch moved without command");
  a_remote: assert property (p_remote) else $error("remote command not applied");
  a_panel: assert property (p_panel) else $error("panel command not applied");
  a_evchg: assert property (p_evchg) else $error("event without state change");
  a_evstate: assert property (p_evstate) else $error("event state differs from switch");
  a_stamp: assert property (p_stamp) else $error("stamp moved without event");
  a_cause: assert property (p_cause) else $error("event without command");
  a_irq: assert property (p_irq) else $error("interrupt rose without cause");
endmodule // lcs_top_checker

bind lcs_top lcs_top_checker #(.NUM_SW(NUM_SW)) u_chk (
  .REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .REG_WR_IN(REG_WR_IN),
  .PANEL_CMD_VALID_IN(PANEL_CMD_VALID_IN), .PANEL_CMD_SWITCH_IN(PANEL_CMD_SWITCH_IN),
  .PANEL_CMD_ON_IN(PANEL_CMD_ON_IN), .PANEL_LEVEL_IN(PANEL_LEVEL_IN),
  .REMOTE_CMD_VALID_IN(REMOTE_CMD_VALID_IN), .REMOTE_CMD_SWITCH_IN(REMOTE_CMD_SWITCH_IN),
  .REMOTE_CMD_ON_IN(REMOTE_CMD_ON_IN), .SWITCH_OUT(SWITCH_OUT), .EVT_VALID_OUT(EVT_VALID_OUT),
  .EVT_STATE_OUT(EVT_STATE_OUT), .EVT_STAMP_OUT(EVT_STAMP_OUT), .IRQ_OUT(IRQ_OUT));

// [test/lcs_cmd_src.sv]
// Model of the local panel and the remote telemetry unit
`timescale 1ns/1ps
module lcs_cmd_src
  import lcs_pkg::*;
(
  input  wire logic    clk_in,
  output logic         pnl_valid_out,
  output logic [2:0]   pnl_sw_out,
  output logic         pnl_on_out,
  output lcs_level_type pnl_level_out,
  output logic         rem_valid_out,
  output logic [2:0]   rem_sw_out,
  output logic         rem_on_out
);
  initial begin
    {pnl_valid_out, pnl_sw_out, pnl_on_out, rem_valid_out, rem_sw_out, rem_on_out} = '0;
    pnl_level_out = LCS_LVL_USER;
  end
  task automatic send(input logic rem, input logic [2:0] sw, input logic on, input lcs_level_type lvl);
    rem_valid_out <= rem;
    pnl_valid_out <= !rem;
    // The idle source shows inverted lines so stale values never look valid
    rem_sw_out    <= rem ? sw : ~rem_sw_out;
    rem_on_out    <= rem ? on : ~rem_on_out;
    pnl_sw_out    <= rem ? ~pnl_sw_out : sw;
    pnl_on_out    <= rem ? ~pnl_on_out : on;
    pnl_level_out <= lvl;
    @(posedge clk_in);
  endtask
  task automatic idle;
    rem_valid_out <= 1'b0;
    pnl_valid_out <= 1'b0;
    rem_sw_out    <= ~rem_sw_out;
    pnl_sw_out    <= ~pnl_sw_out;
    @(posedge clk_in);
  endtask
endmodule // lcs_cmd_src

// [test/testbench.sv]
// Self-checking bench of the latching control switch block
`timescale 1ns/1ps
`include "lcs_defines.svh"
module testbench
  import lcs_pkg::*;
;
  logic          REF_CLK_IN, SRST_IN, REG_WR_IN, REG_RD_IN, IRQ_OUT;
  logic [7:0]    REG_ADDR_IN;
  logic [31:0]   REG_WDATA_IN, REG_RDATA_OUT, EVT_STAMP_OUT;
  logic          pv, pon, rv, ron, rd_d;
  logic [2:0]    psw, rsw;
  lcs_level_type plvl;
  logic [4:0]    SWITCH_OUT, EVT_VALID_OUT, EVT_STATE_OUT, sw_e;
  logic [9:0]    acc_e, stat_e;
  logic [1:0]    evsel_e;
  logic [31:0]   rdq[$], evq[$], ticks, e;
  logic [4:0]    swq[$], sw_seen;
  int            bad_count, checks, i, m;

  lcs_top DUT (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .PANEL_CMD_VALID_IN(pv), .PANEL_CMD_SWITCH_IN(psw),
    .PANEL_CMD_ON_IN(pon), .PANEL_LEVEL_IN(plvl), .REMOTE_CMD_VALID_IN(rv),
    .REMOTE_CMD_SWITCH_IN(rsw), .REMOTE_CMD_ON_IN(ron), .SWITCH_OUT(SWITCH_OUT),
    .EVT_VALID_OUT(EVT_VALID_OUT), .EVT_STATE_OUT(EVT_STATE_OUT),
    .EVT_STAMP_OUT(EVT_STAMP_OUT), .IRQ_OUT(IRQ_OUT));
  lcs_cmd_src u_src (.clk_in(REF_CLK_IN), .pnl_valid_out(pv), .pnl_sw_out(psw), .pnl_on_out(pon),
    .pnl_level_out(plvl), .rem_valid_out(rv), .rem_sw_out(rsw), .rem_on_out(ron));

  initial begin
    REF_CLK_IN = 1'b0;
    forever #20 REF_CLK_IN = ~REF_CLK_IN;
  end

  // ----
  // Checking
  // ----
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge REF_CLK_IN) rd_d <= REG_RD_IN;
  // Tick count since reset release, mirrors the free-running stamp
  always @(posedge REF_CLK_IN) ticks <= SRST_IN ? 32'h0 : ticks + 32'h1;
  always @(negedge REF_CLK_IN) begin
    if (rd_d) begin
      e = rdq.pop_front();
      // All ones asks for the live tick count, one cycle behind here
      cmp("rdata", (e === 32'hFFFF_FFFF) ? ticks - 32'h1 : e, REG_RDATA_OUT);
    end else if (REG_RDATA_OUT !== 32'h0) begin
      cmp("rdata idle", 32'h0, REG_RDATA_OUT);
    end
    if (EVT_VALID_OUT !== 5'h0) begin
      cmp("event", evq.size() ? evq.pop_front() : 32'h0,
          {EVT_VALID_OUT, EVT_STATE_OUT & EVT_VALID_OUT});
      // The stamp is taken one cycle before the event shows
      cmp("stamp", ticks - 32'h1, EVT_STAMP_OUT);
    end
    if (SWITCH_OUT !== sw_seen) begin
      cmp("switch", swq.size() ? {27'h0, swq.pop_front()} : {27'h0, sw_seen}, {27'h0, SWITCH_OUT});
      sw_seen = SWITCH_OUT;
    end
  end
  initial begin
    repeat (20000) @(posedge REF_CLK_IN);
    bad_count++;
    final_report();
  end

  // ----
  // Drivers
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    @(posedge REF_CLK_IN);
    REG_WR_IN <= 1'b0;
    REG_WDATA_IN <= ~d;
    @(posedge REF_CLK_IN);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= a;
    rdq.push_back(e);
    @(posedge REF_CLK_IN);
    REG_RD_IN <= 1'b0;
    REG_ADDR_IN <= ~a;
    @(posedge REF_CLK_IN);
  endtask
  task automatic cmd(input logic rem, input logic [2:0] sw, input logic on, input lcs_level_type lvl);
    logic [4:0] b;
    b = 5'h1 << sw;
    if (sw < 3'h5 && (rem || lvl >= acc_e[2*sw +: 2]) && sw_e[sw] !== on) begin
      sw_e[sw] = on;
      swq.push_back(sw_e);
      stat_e = stat_e | (on ? {5'h0, b} : {b, 5'h0});
      if (evsel_e[on ? 0 : 1]) evq.push_back({22'h0, b, on ? b : 5'h0});
    end
    u_src.send(rem, sw, on, lvl);
  endtask

  initial begin
    {REG_WR_IN, REG_RD_IN, REG_ADDR_IN, REG_WDATA_IN, rd_d} = '0;
    {bad_count, checks, sw_e, stat_e, sw_seen} = '0;
    SRST_IN = 1'b1;
    acc_e = 10'h2AA;
    evsel_e = 2'h3;
    void'($urandom(32'hae8a1e16));
    repeat (10) @(posedge REF_CLK_IN);
    SRST_IN <= 1'b0;
    @(posedge REF_CLK_IN);
    rd(`LCS_OFF_ACCESS, 32'h0000_02AA);
    rd(`LCS_OFF_EVSEL, 32'h0000_0003);
    rd(8'h18, 32'h0000_0000);
    rd(`LCS_OFF_STAMP, 32'hFFFF_FFFF);
    for (i = 0; i < 5; i++) begin
      rd(`LCS_OFF_LABEL + 8'(32 * i), `LCS_LABEL_W0);
      rd(`LCS_OFF_LABEL + 8'(32 * i + 4), `LCS_LABEL_W1 | (32'(`LCS_ASCII_ONE + i) << 16));
    end
    wr(8'hDC, 32'h5A5A_0F0F);
    rd(8'hDC, 32'h5A5A_0F0F);
    for (m = 0; m < 4; m++) begin
      acc_e = 10'($urandom);
      evsel_e = 2'(m);
      wr(`LCS_OFF_ACCESS, {22'h0, acc_e});
      wr(`LCS_OFF_EVSEL, {30'h0, evsel_e});
      repeat (40) cmd(1'($urandom), 3'($urandom), 1'($urandom), lcs_level_type'(2'($urandom)));
      u_src.idle();
      wr(`LCS_OFF_STATE, {27'h0, ~sw_e});
      rd(`LCS_OFF_STATE, {27'h0, sw_e});
    end
    rd(`LCS_OFF_IRQ_STAT, {22'h0, stat_e});
    cmp("irq masked", 32'h0, {31'h0, IRQ_OUT});
    wr(`LCS_OFF_IRQ_MASK, 32'h0000_03FF);
    @(posedge REF_CLK_IN);
    cmp("irq", {31'h0, stat_e != 10'h0}, {31'h0, IRQ_OUT});
    wr(`LCS_OFF_IRQ_STAT, 32'h0000_03FF);
    @(posedge REF_CLK_IN);
    cmp("irq clear", 32'h0, {31'h0, IRQ_OUT});
    stat_e = 10'h0;
    wr(`LCS_OFF_IRQ_MASK, 32'h0000_0000);
    cmd(1'b1, 3'h0, ~sw_e[0], LCS_LVL_USER);
    u_src.idle();
    repeat (3) @(posedge REF_CLK_IN);
    cmp("irq off", 32'h0, {31'h0, IRQ_OUT});
    rd(`LCS_OFF_IRQ_STAT, {22'h0, stat_e});
    cmp("events left", 32'h0, 32'(evq.size()));
    cmp("switches left", 32'h0, 32'(swq.size()));
    final_report();
  end
endmodule // testbench
